// ---- verilog/adc_core.sv ----
`timescale 1ns/100ps
// Contract
// RULE1: output word is 14 bits of difference
// RULE2: new sample each clock, eight-clock latency
// RULE3: word and range flag registered together
// RULE4: capture input on rising sample edge
// RULE5: stabilizer makes internal clock 50% duty
// RULE6: format pin picks binary or twos complement
// RULE7: swapped inputs give complemented word
// RULE8: ten-stage pipeline with redundancy correction
// RULE9: board straps format pin level
// RULE10: saturate with flag; midscale is 2000 hex
// RULE11: capture relates words with fixed latency
module adc_core
  import adc_pkg::*;
#(
  parameter int DEPTH = adc_pkg::FIFO_DEPTH
) (
  input  wire logic                   i_mclk,                  // system clock
  input  wire logic                   i_nrst,                  // async reset, active low
  input  wire logic                   i_sample_clk,            // external sample clock pin
  input  wire logic [adc_pkg::IN_W-1:0] i_vin_pos,             // positive input level
  input  wire logic [adc_pkg::IN_W-1:0] i_vin_neg,             // negative input level
  input  wire logic [adc_pkg::IN_W-1:0] i_vref,                // reference, full span
  input  wire logic                   i_output_format_select,  // 1: twos complement
  input  wire logic                   i_duty_cycle_stabilizer, // 1: stabilizer on
  input  wire logic                   i_capture_ready,         // downstream accepts
  output      adc_pkg::word_t         o_word,                  // data and range flag
  output      logic                   o_word_valid,            // word present
  output      logic                   o_fifo_ready,            // buffer has room
  output      logic                   o_int_clk                // internal clock
);
  import adc_pkg::*;

  // ten stages: nine redundant 1.5-bit stages plus a 5-bit flash
  function automatic word_t convert(input logic [IN_W-1:0] vp, input logic [IN_W-1:0] vn,
                                    input logic [IN_W-1:0] vr);
    int    fs;
    int    v;
    int    r;
    int    d;
    int    acc;
    int    f;
    word_t w;
    fs  = (int'(vr) / 2 > 0) ? int'(vr) / 2 : 1;
    v   = int'(vp) - int'(vn);
    r   = (v > fs) ? fs : ((v < -fs) ? -fs : v);
    acc = CODE_HALF;
    for (int i = 0; i < NUM_STAGES - 1; i++) begin
      d   = (r > fs / 4) ? 1 : ((r < -(fs / 4)) ? -1 : 0);
      r   = 2 * r - d * fs;
      acc = acc + d * (1 << (12 - i));
    end
    f   = ((r + fs) * FLASH_HALF) / fs;
    f   = (f > FLASH_MAX) ? FLASH_MAX : ((f < 0) ? 0 : f);
    acc = acc + f - FLASH_HALF;
    acc = (acc > CODE_MAX) ? CODE_MAX : ((acc < 0) ? 0 : acc);
    w.data = acc[DATA_W-1:0];
    // upper flag trips half an LSB below full scale, one LSB being fs / CODE_HALF
    w.out_of_range_flag  = (v < -fs) || (2 * v * CODE_HALF > fs * CODE_MAX);
    return w;
  endfunction

  logic [SYNC_STAGES-1:0] clk_s_q;
  logic [SYNC_STAGES-1:0] fmt_s_q;
  logic [SYNC_STAGES-1:0] dcs_s_q;
  logic                   clk_lvl_q;
  logic                   fmt_lvl_q;
  logic                   dcs_lvl_q;
  logic [CNT_W-1:0]       cnt_q;
  logic [CNT_W-1:0]       period_q;
  word_t                  sample_q;
  word_t                  pipe_q [LATENCY-1];
  // one valid mark per stage, the held sample included, so no reset word escapes
  logic [LATENCY-1:0]     pvld_q;
  logic                   int_clk_d;

  wire        rise     = clk_s_q[1] && clk_s_q[2] && !clk_lvl_q;
  wire        clk_stab = (clk_s_q[1] == clk_s_q[2]);
  wire word_t conv     = convert(i_vin_pos, i_vin_neg, i_vref); // RULE1 RULE7 RULE8 RULE10
  wire word_t tail     = pipe_q[LATENCY-2];
  wire        wr_en    = rise && pvld_q[LATENCY-1];
  wire        fifo_in_rdy;
  wire        fifo_vld;
  wire word_t fifo_word;
  wire        load_out = fifo_vld && (!o_word_valid || i_capture_ready);
  wire fmt_t  fmt      = fmt_t'(fmt_lvl_q);
  wire word_t fmt_word = '{data: (fmt == FMT_TWOS) ? {~fifo_word.data[DATA_W-1],
                                                      fifo_word.data[DATA_W-2:0]}
                                                   : fifo_word.data,
                           out_of_range_flag:  fifo_word.out_of_range_flag};                 // RULE6
  wire [CNT_W-1:0] half = period_q >> 1;

  // stabilizer: falls at half the measured period, else follows the pin
  always_comb begin
    if (rise) begin
      int_clk_d = 1'b1;
    end else if (dcs_lvl_q) begin
      int_clk_d = o_int_clk && (cnt_q + 1'b1 < half);            // RULE5
    end else begin
      int_clk_d = clk_stab ? clk_s_q[2] : o_int_clk;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      clk_s_q   <= '0;
      fmt_s_q   <= '0;
      dcs_s_q   <= '0;
      clk_lvl_q <= 1'b0;
      fmt_lvl_q <= 1'b0;
      dcs_lvl_q <= 1'b0;
    end else begin
      clk_s_q <= {clk_s_q[1:0], i_sample_clk};
      fmt_s_q <= {fmt_s_q[1:0], i_output_format_select};
      dcs_s_q <= {dcs_s_q[1:0], i_duty_cycle_stabilizer};
      if (clk_stab) begin
        clk_lvl_q <= clk_s_q[2];
      end
      if (fmt_s_q[1] == fmt_s_q[2]) begin
        fmt_lvl_q <= fmt_s_q[2];
      end
      if (dcs_s_q[1] == dcs_s_q[2]) begin
        dcs_lvl_q <= dcs_s_q[2];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q     <= '0;
      period_q  <= '0;
      o_int_clk <= 1'b0;
    end else begin
      cnt_q     <= rise ? '0 : cnt_q + 1'b1;
      o_int_clk <= int_clk_d;
      if (rise) begin
        period_q <= cnt_q + 1'b1;
      end
    end
  end

  // sample held between rising edges, then shifted one stage per edge
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sample_q <= '0;
      pvld_q   <= '0;
      for (int k = 0; k < LATENCY - 1; k++) begin
        pipe_q[k] <= '0;
      end
    end else if (rise) begin
      sample_q  <= conv;                                         // RULE4
      pipe_q[0] <= sample_q;                                     // RULE2
      for (int k = 1; k < LATENCY - 1; k++) begin
        pipe_q[k] <= pipe_q[k-1];
      end
      pvld_q <= {pvld_q[LATENCY-2:0], 1'b1};
    end
  end

  word_fifo #(
    .W     ($bits(word_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_mclk      (i_mclk),
    .i_nrst      (i_nrst),
    .i_in_valid  (wr_en),
    .o_in_ready  (fifo_in_rdy),
    .i_in_data   (tail),
    .o_out_valid (fifo_vld),
    .i_out_ready (load_out),
    .o_out_data  (fifo_word)
  );

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_word       <= '0;
      o_word_valid <= 1'b0;
      o_fifo_ready <= 1'b0;
    end else begin
      o_fifo_ready <= fifo_in_rdy;
      if (load_out) begin
        o_word       <= fmt_word;                                // RULE3
        o_word_valid <= 1'b1;
      end else if (i_capture_ready) begin
        o_word_valid <= 1'b0;
      end
    end
  end

  sequence rise_s;
    rise;
  endsequence
  sequence no_rise_s;
    !rise;
  endsequence

  hold_sample_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // RULE4
    no_rise_s |=> sample_q == $past(sample_q)) else $error("sample moved without edge");
  take_sample_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // RULE4
    rise_s |=> sample_q == $past(conv)) else $error("sample not taken on edge");
  pipe_delay_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // RULE2
    rise_s |=> pipe_q[LATENCY-2] == $past(pipe_q[LATENCY-3]))
    else $error("pipeline did not advance");
  mid_code_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // RULE10
    (i_vin_pos == i_vin_neg && i_vref > 16'h0003) |-> conv.data == MID_CODE && !conv.out_of_range_flag)
    else $error("midscale code wrong");
  sat_flag_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // RULE10
    conv.out_of_range_flag |-> conv.data == MIN_CODE || conv.data == MAX_CODE)
    else $error("out of range without full scale code");
  high_flag_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // RULE10
    (i_vref > 16'h0003 && int'(i_vin_pos) - int'(i_vin_neg) > int'(i_vref) / 2)
    |-> conv.out_of_range_flag && conv.data == MAX_CODE) else $error("above full scale not flagged");
  out_hold_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // RULE3
    (o_word_valid && !i_capture_ready) |=> $stable(o_word) && o_word_valid)
    else $error("word changed while stalled");
  out_load_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // RULE6
    load_out |=> o_word.out_of_range_flag == $past(fifo_word.out_of_range_flag) &&
      o_word.data[DATA_W-1] == ($past(fifo_word.data[DATA_W-1]) ^ $past(fmt_lvl_q)))
    else $error("format or flag wrong at output");
  dcs_fall_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // RULE5
    (dcs_lvl_q && !rise && o_int_clk && cnt_q + 1'b1 >= half) |=> !o_int_clk)
    else $error("internal clock did not fall at half period");
  dcs_rise_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // RULE5
    rise_s |=> o_int_clk) else $error("internal clock did not rise");
endmodule

// ---- verilog/adc_pkg.sv ----
package adc_pkg;
  localparam int          DATA_W      = 14;
  localparam int          IN_W        = 16;
  localparam int          LATENCY     = 8;
  localparam int          SYNC_STAGES = 3;
  localparam int          NUM_STAGES  = 10;
  localparam int          FLASH_HALF  = 16;
  localparam int          FLASH_MAX   = 31;
  localparam int          FIFO_DEPTH  = 8;
  localparam int          CNT_W       = 16;
  localparam int          CODE_MAX    = 16383;
  localparam int          CODE_HALF   = 8192;
  localparam logic [13:0] MIN_CODE    = 14'h0000;
  localparam logic [13:0] MID_CODE    = 14'h2000;
  localparam logic [13:0] MAX_CODE    = 14'h3FFF;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              out_of_range_flag;
  } word_t;

  typedef enum logic [0:0] {
    FMT_BINARY = 1'b0,
    FMT_TWOS   = 1'b1
  } fmt_t;
endpackage

// ---- verilog/word_fifo.sv ----
`timescale 1ns/100ps
module word_fifo #(
  parameter int W     = 15,
  parameter int DEPTH = 8
) (
  input  wire logic         i_mclk,      // clock
  input  wire logic         i_nrst,      // async reset, active low
  input  wire logic         i_in_valid,  // write request
  output      logic         o_in_ready,  // not full
  input  wire logic [W-1:0] i_in_data,   // write data
  output      logic         o_out_valid, // not empty
  input  wire logic         i_out_ready, // read accept
  output      logic [W-1:0] o_out_data   // head word
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0]   cnt_q;
  wire           push = i_in_valid && o_in_ready;
  wire           pop  = o_out_valid && i_out_ready;

  assign o_in_ready  = (cnt_q != (PW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem[rd_q];

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// ---- verif/capture_model.sv ----
`timescale 1ns/100ps
module capture_model
  import adc_pkg::*;
(
  input  wire logic           i_mclk,     // clock
  input  wire logic           i_nrst,     // async reset, active low
  input  wire logic           i_stall,    // hold off accepting
  input  wire adc_pkg::word_t i_word,     // word from converter
  input  wire logic           i_valid,    // word present
  output      logic           o_ready,    // accepting this cycle
  output      adc_pkg::word_t o_got_q,    // last captured word
  output      logic           o_got_stb_q // pulses once per capture
);
  assign o_ready = !i_stall;
  // word and range flag taken on one edge
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_got_q     <= '0;
      o_got_stb_q <= 1'b0;
    end else begin
      o_got_stb_q <= i_valid && o_ready;
      if (i_valid && o_ready) begin
        o_got_q <= i_word;
      end
    end
  end
endmodule

// ---- verif/pipelined_adc_output_timing_test.sv ----
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
  end \
end
module pipelined_adc_output_timing_test;
  import adc_pkg::*;
  logic        mclk     = 1'b0;
  logic        nrst     = 1'b0;
  logic        sclk     = 1'b0;
  logic [15:0] vin_pos  = 16'h8000;
  logic [15:0] vin_neg  = 16'h8000;
  logic [15:0] vref     = 16'h4000;
  logic        fmt      = 1'b0;
  logic        duty_cycle_stabilizer      = 1'b0;
  logic        stall    = 1'b0;
  logic        seen_max = 1'b0;
  word_t       word;
  word_t       got;
  logic        valid;
  logic        fifo_rdy;
  logic        int_clk;
  logic        cap_ready;
  logic        got_stb;
  logic [14:0] s;
  int          errors, checks_done, cycles, words, run, last_hi;

  adc_core dut (.i_mclk(mclk), .i_nrst(nrst), .i_sample_clk(sclk), .i_vin_pos(vin_pos),
    .i_vin_neg(vin_neg), .i_vref(vref), .i_output_format_select(fmt),
    .i_duty_cycle_stabilizer(duty_cycle_stabilizer), .i_capture_ready(cap_ready), .o_word(word),
    .o_word_valid(valid), .o_fifo_ready(fifo_rdy), .o_int_clk(int_clk));
  capture_model cap (.i_mclk(mclk), .i_nrst(nrst), .i_stall(stall), .i_word(word),
    .i_valid(valid), .o_ready(cap_ready), .o_got_q(got), .o_got_stb_q(got_stb));

  always #5 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (got_stb) begin
      words++;
      if (got.data === 14'h3FFF) seen_max = 1'b1;
    end
    if (int_clk === 1'b1) run++;
    else if (run != 0) begin
      last_hi = run;
      run = 0;
    end
    if (cycles > 6000) begin
      errors++;
      test_done();
    end
  end

  task automatic sclk_cycle(input int hi, input int lo);
    sclk <= 1'b1;
    repeat (hi) @(posedge mclk);
    sclk <= 1'b0;
    repeat (lo) @(posedge mclk);
  endtask

  task automatic conv(input logic [15:0] p, input logic [15:0] n);
    vin_pos <= p;
    vin_neg <= n;
    repeat (10) sclk_cycle(4, 4);
  endtask

  task automatic t_codes;
    logic [15:0] pos [3] = '{16'h8000, 16'hA100, 16'h5F00};
    logic [13:0] bin [3] = '{14'h2000, 14'h3FFF, 14'h0000};
    for (int f = 0; f < 2; f++) begin
      fmt <= f[0];
      for (int i = 0; i < 3; i++) begin
        conv(pos[i], 16'h8000);
        `CHK("code", {bin[i] ^ (f[0] ? 14'h2000 : 14'h0000), i != 0}, got)
        `CHK("data", bin[i] ^ (f[0] ? 14'h2000 : 14'h0000), got.data)
      end
    end
    fmt <= 1'b0;
    $display("test codes done");
  endtask

  task automatic t_latency;
    conv(16'h8000, 16'h8000);
    seen_max = 1'b0;
    vin_pos <= 16'hA100;
    sclk_cycle(4, 4);
    vin_pos <= 16'h8000;
    repeat (7) sclk_cycle(4, 4);
    `CHK("early", 1'b0, seen_max)
    sclk_cycle(4, 4);
    `CHK("on time", 1'b1, seen_max)
    $display("test latency done");
  endtask

  task automatic t_swap;
    conv(16'h9000, 16'h8000);
    `CHK("plus", {14'h3000, 1'b0}, got)
    s = {1'b0, got.data};
    conv(16'h8000, 16'h9000);
    s = s + {1'b0, got.data};
    `CHK("swap", 1'b1, (s >= 15'h3FFE) && (s <= 15'h4000))
    $display("test swap done");
  endtask

  task automatic t_fifo;
    int n0;
    stall <= 1'b1;
    repeat (12) sclk_cycle(4, 4);
    `CHK("full", 1'b0, fifo_rdy)
    `CHK("held", 1'b1, valid)
    n0 = words;
    stall <= 1'b0;
    repeat (20) @(posedge mclk);
    `CHK("drained", 1'b1, (words - n0) >= FIFO_DEPTH)
    `CHK("empty", 1'b0, valid)
    `CHK("room", 1'b1, fifo_rdy)
    $display("test fifo done");
  endtask

  task automatic t_dcs;
    duty_cycle_stabilizer <= 1'b1;
    repeat (4) sclk_cycle(2, 10);
    `CHK("half", 1'b1, (last_hi >= 5) && (last_hi <= 7))
    duty_cycle_stabilizer <= 1'b0;
    repeat (4) sclk_cycle(2, 10);
    `CHK("follow", 1'b1, (last_hi >= 1) && (last_hi <= 3))
    $display("test stabilizer done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    t_codes();
    t_latency();
    t_swap();
    t_fifo();
    t_dcs();
    test_done();
  end
endmodule
